// file: design/nbcp_device.sv
`timescale 1ns/100ps
module nbcp_device (
    input wire logic rst,
    nbcp_if.dev dif,
    output logic cmd_valid,
    output logic [nbcp_pkg::DQ_W-1:0] cmd_byte,
    output logic addr_valid,
    output logic [nbcp_pkg::DQ_W-1:0] addr_byte,
    output logic wdata_valid,
    output logic [nbcp_pkg::DQ_W-1:0] wdata,
    input wire logic [nbcp_pkg::DQ_W-1:0] rdata,
    output logic rdata_take,
    input wire logic busy
);
    import nbcp_pkg::*;
    logic sel;
    logic is_cmd;
    logic is_addr;
    logic is_win;
    logic is_rd;
    logic [7:0] last_cmd;
    logic busy_kind;
    logic in_phase;
    logic out_phase;
    logic own;
    logic dqs_q;
    logic [DQ_W-1:0] dq_q;
    logic rb_q;

    // (RL8) Controls count only at rising edges.
    assign sel = ~dif.ce_n;
    assign is_cmd = sel & dif.cle & ~dif.ale & dif.wr_n;
    assign is_addr = sel & ~dif.cle & dif.ale & dif.wr_n;
    assign is_win = sel & dif.cle & dif.ale & dif.wr_n;
    assign is_rd = sel & dif.cle & dif.ale & ~dif.wr_n & own;
    // (RL12) Each output byte of a doubled-output command sent twice.
    assign rdata_take = is_rd & (~dbl_out_cmd(last_cmd) | out_phase);

    always_ff @(posedge dif.link_clk) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd_byte <= '0;
            addr_valid <= 1'b0;
            addr_byte <= '0;
            last_cmd <= 8'h00;
            busy_kind <= 1'b0;
        end else begin
            cmd_valid <= is_cmd;
            addr_valid <= is_addr;
            if (is_cmd) begin
                cmd_byte <= dif.dq;
                last_cmd <= dif.dq;
                busy_kind <= busy_cmd(dif.dq);
            end
            if (is_addr) begin
                addr_byte <= dif.dq;
            end
        end
    end

    always_ff @(posedge dif.link_clk) begin
        if (rst) begin
            wdata_valid <= 1'b0;
            wdata <= '0;
            in_phase <= 1'b0;
        end else begin
            // (RL6) Keep one copy only.
            wdata_valid <= is_win & ~in_phase;
            if (is_win & ~in_phase) begin
                wdata <= dif.dq;
            end
            if (is_cmd) begin
                in_phase <= 1'b0;
            end else if (is_win && last_cmd == OP_SET_FEAT) begin
                in_phase <= ~in_phase;
            end
        end
    end

    always_ff @(posedge dif.link_clk) begin
        if (rst) begin
            own <= 1'b0;
            dqs_q <= 1'b0;
            dq_q <= '0;
            out_phase <= 1'b0;
        end else begin
            // (RL14) Ownership follows direction.
            own <= ~dif.wr_n;
            if (!own) begin
                // (RL16) Strobe driven low first.
                dqs_q <= 1'b0;
                out_phase <= 1'b0;
            end else if (is_rd) begin
                dqs_q <= ~dqs_q;
                dq_q <= rdata;
                out_phase <= dbl_out_cmd(last_cmd) & ~out_phase;
            end
        end
    end

    always_ff @(posedge dif.link_clk) begin
        if (rst) begin
            rb_q <= 1'b1;
        end else begin
            // (RL1) Busy only for busy commands.
            rb_q <= ~(busy & busy_kind);
        end
    end

    // (RL17) Release as soon as direction goes high.
    assign dif.dq_d_oe = own & ~dif.wr_n;
    assign dif.dqs_d_oe = own & ~dif.wr_n;
    assign dif.dq_d = dq_q;
    assign dif.dqs_d = dqs_q;
    assign dif.rb_n = rb_q;
endmodule // nbcp_device

// file: design/nbcp_host.sv
// Functional notes
// (RL1) Busy line only for busy commands.
// (RL2) Chip select setup and hold met.
// (RL3) Chip select access and hold met.
// (RL4) Held-data read below thirty ns period.
// (RL5) Chip select asserted early enough.
// (RL6) Set features bytes doubled, one kept.
// (RL7) Clock stop only when device allows.
// (RL8) Device samples controls on rising edges.
// (RL9) Restart delay after a pause.
// (RL10) Strobe steady around clock restart.
// (RL11) No read start before strobe drive.
// (RL12) Doubled read bytes, keep one copy.
// (RL13) Direction turnaround after read counted.
// (RL14) Bus owner follows direction.
// (RL15) Host releases bus while reading.
// (RL16) Device drives strobe low promptly.
// (RL17) Device releases bus promptly.
// (RL18) All pending delays are met before a read starts; commands and addresses do not wait on gap.
// (RL19) Governing delays set the wait.
// (RL20) Strobe widths half a period.
// (RL21) Delays are configurable counts.
`timescale 1ns/100ps
module nbcp_host #(
    // (RL21) Delays as cycle parameters.
    parameter logic [7:0] CS_SETUP = nbcp_pkg::CS_SETUP_CYC,
    parameter logic [7:0] CS_HOLD = nbcp_pkg::CS_HOLD_CYC,
    parameter logic [7:0] CS_ACCESS = nbcp_pkg::CS_ACCESS_CYC,
    parameter logic [7:0] ADL = nbcp_pkg::ADL_CYC,
    parameter logic [7:0] CCS = nbcp_pkg::CCS_CYC,
    parameter logic [7:0] RHW = nbcp_pkg::RHW_CYC,
    parameter logic [7:0] WHR = nbcp_pkg::WHR_CYC,
    parameter logic [7:0] DQSD = nbcp_pkg::DQSD_CYC,
    parameter logic [7:0] TURN = nbcp_pkg::TURN_CYC,
    parameter logic [7:0] RESTART = nbcp_pkg::RESTART_CYC
) (
    input wire logic clk,
    input wire logic rst,
    nbcp_if.host hif,
    input wire logic req_valid,
    input wire logic [1:0] req_kind,
    input wire logic req_last,
    input wire logic [nbcp_pkg::DQ_W-1:0] req_byte,
    output logic req_ready,
    output logic rsp_valid,
    output logic [nbcp_pkg::DQ_W-1:0] rsp_byte,
    input wire logic clk_stop_en,
    input wire logic dev_stop_ok,
    output logic ready
);
    import nbcp_pkg::*;
    nbcp_hstate_t state;
    logic [1:0] dcnt;
    logic tick;
    logic hold;
    logic [7:0] wcnt;
    logic [7:0] gap;
    logic [7:0] last_cmd;
    logic rep;
    logic ending;
    logic wrote;
    logic ce_n;
    logic cle;
    logic ale;
    logic wr_n;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic dqs_drv;
    logic [DQ_W+1:0] s_in;
    logic dqs_prev;
    logic dqs_late;
    logic rphase;
    logic edge_seen;
    logic run_take;
    logic rd_take;

    assign tick = (dcnt == 2'(LINK_DIV - 1));
    // (RL6) Second copy before taking.
    assign run_take = (state == H_RUN) && tick && req_valid &&
        (req_kind == K_CMD || req_kind == K_ADDR ||
        (req_kind == K_WRITE && gap == 8'h00 && (last_cmd != OP_SET_FEAT || rep)));
    // (RL12) Each doubled-output read byte covers two cycles.
    assign rd_take = (state == H_RD) && tick && req_valid && req_kind == K_READ &&
        (!dbl_out_cmd(last_cmd) || rep);
    assign req_ready = run_take | rd_take;

    always_ff @(posedge clk) begin
        if (rst) begin
            dcnt <= 2'h0;
        end else begin
            dcnt <= dcnt + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wcnt <= 8'h00;
            gap <= 8'h00;
        end else begin
            if (wcnt != 8'h00) begin
                wcnt <= wcnt - 8'h01;
            end
            if (gap != 8'h00) begin
                gap <= gap - 8'h01;
            end
            if (state == H_IDLE && req_valid) begin
                // (RL5) Select setup before first edge.
                wcnt <= CS_SETUP;
            end else if (state == H_SETUP && tick && wcnt == 8'h00) begin
                // (RL3) Access time before data.
                gap <= CS_ACCESS;
            end else if (run_take && req_kind == K_CMD) begin
                // (RL19) Governing delay after command.
                gap <= (req_byte == OP_COL_CHANGE) ? max8(WHR, CCS) : WHR;
            end else if (run_take && req_kind == K_ADDR) begin
                gap <= max8(ADL, CCS);
            end else if (run_take && req_last) begin
                // (RL2) Select hold after a last write cycle.
                wcnt <= CS_HOLD;
            end else if (state == H_RUN && tick && req_valid && req_kind == K_READ) begin
                // (RL11) Strobe drive delay first.
                wcnt <= DQSD;
            end else if (state == H_PAUSE && tick && req_valid) begin
                // (RL9) Restart delay after pause.
                wcnt <= RESTART;
            end else if (state == H_RD && tick && (rd_take ? req_last : req_valid &&
                    req_kind != K_READ)) begin
                // (RL13) Turnaround before direction rises.
                wcnt <= TURN;
            end else if (state == H_TURN && tick && wcnt == 8'h00) begin
                gap <= RHW;
                wcnt <= CS_HOLD;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= H_IDLE;
            ce_n <= 1'b1;
            cle <= 1'b0;
            ale <= 1'b0;
            wr_n <= 1'b1;
            dq_o <= '0;
            dq_oe <= 1'b1;
            dqs_drv <= 1'b0;
            hold <= 1'b0;
            rep <= 1'b0;
            ending <= 1'b0;
            wrote <= 1'b0;
            last_cmd <= 8'h00;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (req_valid) begin
                        ce_n <= 1'b0;
                        state <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (tick && wcnt == 8'h00) begin
                        state <= H_RUN;
                    end
                end
                H_RUN: begin
                    if (tick) begin
                        cle <= 1'b0;
                        ale <= 1'b0;
                        dqs_drv <= 1'b0;
                        if (run_take) begin
                            cle <= (req_kind != K_ADDR);
                            ale <= (req_kind != K_CMD);
                            dq_o <= req_byte;
                            // (RL20) Strobe follows half clock phase.
                            dqs_drv <= (req_kind == K_WRITE);
                            wrote <= (req_kind == K_WRITE);
                            rep <= 1'b0;
                            if (req_kind == K_CMD) begin
                                last_cmd <= req_byte;
                            end
                            if (req_last) begin
                                state <= H_HOLD;
                            end
                        end else if (req_valid && req_kind == K_WRITE && gap == 8'h00) begin
                            cle <= 1'b1;
                            ale <= 1'b1;
                            dq_o <= req_byte;
                            dqs_drv <= 1'b1;
                            rep <= 1'b1;
                        end else if (req_valid && req_kind == K_READ) begin
                            // (RL15) Release bus before reading.
                            wr_n <= 1'b0;
                            dq_oe <= 1'b0;
                            rep <= 1'b0;
                            state <= H_RDSTART;
                        end else if (!req_valid && wrote && clk_stop_en && dev_stop_ok) begin
                            // (RL7) Stop clock only if allowed.
                            hold <= 1'b1;
                            state <= H_PAUSE;
                        end
                    end
                end
                H_PAUSE: begin
                    if (tick && req_valid) begin
                        hold <= 1'b0;
                        state <= H_RESTART;
                    end
                end
                H_RESTART: begin
                    // (RL10) Strobe held low across restart.
                    if (tick && wcnt == 8'h00) begin
                        state <= H_RUN;
                    end
                end
                H_RDSTART: begin
                    // (RL18) Every pending delay met.
                    if (tick && wcnt == 8'h00 && gap == 8'h00) begin
                        state <= H_RD;
                    end
                end
                H_RD: begin
                    if (tick) begin
                        cle <= 1'b0;
                        ale <= 1'b0;
                        if (req_valid && req_kind == K_READ) begin
                            cle <= 1'b1;
                            ale <= 1'b1;
                            rep <= !rd_take;
                            if (rd_take && req_last) begin
                                ending <= 1'b1;
                                state <= H_TURN;
                            end
                        end else if (req_valid) begin
                            state <= H_TURN;
                        end
                    end
                end
                H_TURN: begin
                    if (tick) begin
                        cle <= 1'b0;
                        ale <= 1'b0;
                    end
                    if (tick && wcnt == 8'h00) begin
                        // (RL14) Host takes bus back.
                        wr_n <= 1'b1;
                        dq_oe <= 1'b1;
                        wrote <= 1'b0;
                        ending <= 1'b0;
                        state <= ending ? H_HOLD : H_RUN;
                    end
                end
                H_HOLD: begin
                    if (tick) begin
                        cle <= 1'b0;
                        ale <= 1'b0;
                        dqs_drv <= 1'b0;
                    end
                    if (tick && wcnt == 8'h00) begin
                        ce_n <= 1'b1;
                        wrote <= 1'b0;
                        state <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    nbcp_sync #(.W(DQ_W + 2)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({hif.rb_n, hif.dqs, hif.dq}),
        .q(s_in)
    );

    assign ready = s_in[DQ_W+1];
    // (RL4) Held data taken a stage late.
    assign edge_seen = (EDO_MODE ? (dqs_prev != dqs_late) : (s_in[DQ_W] != dqs_prev)) &&
        (state == H_RD || state == H_TURN);

    always_ff @(posedge clk) begin
        if (rst) begin
            dqs_prev <= 1'b0;
            dqs_late <= 1'b0;
            rphase <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_byte <= '0;
        end else begin
            dqs_prev <= s_in[DQ_W];
            dqs_late <= dqs_prev;
            rsp_valid <= 1'b0;
            if (state == H_RDSTART) begin
                rphase <= 1'b0;
            end else if (edge_seen) begin
                // (RL12) Keep first copy only.
                rphase <= dbl_out_cmd(last_cmd) & ~rphase;
                rsp_valid <= ~rphase;
                // (RL4) Held data sampled late.
                rsp_byte <= s_in[DQ_W-1:0];
            end
        end
    end

    assign hif.link_clk = dcnt[1] | hold;
    assign hif.ce_n = ce_n;
    assign hif.cle = cle;
    assign hif.ale = ale;
    assign hif.wr_n = wr_n;
    assign hif.dq_h = dq_o;
    assign hif.dq_h_oe = dq_oe & wr_n;
    assign hif.dqs_h = dqs_drv & dcnt[1];
    assign hif.dqs_h_oe = dq_oe & wr_n;
endmodule // nbcp_host

// file: design/nbcp_if.sv
`timescale 1ns/100ps
interface nbcp_if;
    import nbcp_pkg::*;
    logic link_clk;
    logic ce_n;
    logic cle;
    logic ale;
    logic wr_n;
    logic [DQ_W-1:0] dq_h;
    logic dq_h_oe;
    logic dqs_h;
    logic dqs_h_oe;
    logic [DQ_W-1:0] dq_d;
    logic dq_d_oe;
    logic dqs_d;
    logic dqs_d_oe;
    logic rb_n;
    logic [DQ_W-1:0] dq;
    logic dqs;

    // Wire level from the enables; undriven data lines read as pulled high, an undriven strobe as low.
    assign dq = dq_h_oe ? dq_h : (dq_d_oe ? dq_d : {DQ_W{1'b1}});
    assign dqs = dqs_h_oe ? dqs_h : (dqs_d_oe ? dqs_d : 1'b0);

    modport host (output link_clk, ce_n, cle, ale, wr_n, dq_h, dq_h_oe, dqs_h, dqs_h_oe,
        input dq, dqs, rb_n);
    modport dev (input link_clk, ce_n, cle, ale, wr_n, dq, dqs,
        output dq_d, dq_d_oe, dqs_d, dqs_d_oe, rb_n);
endinterface

// file: design/nbcp_pkg.sv
package nbcp_pkg;
    localparam int DQ_W = 8;
    localparam int CLK_PERIOD_NS = 4;
    localparam int LINK_DIV = 4;
    localparam int LINK_PERIOD_NS = CLK_PERIOD_NS * LINK_DIV;
    localparam int CS_SETUP_NS = 15;
    localparam int CS_HOLD_NS = 3;
    localparam int CS_ACCESS_NS = 25;
    localparam int ADDR_TO_DATA_NS = 70;
    localparam int COL_CHANGE_NS = 70;
    localparam int READ_HIGH_TO_WRITE_NS = 100;
    localparam int WRITE_HIGH_TO_READ_NS = 60;
    localparam int STROBE_DRIVE_NS = 20;
    localparam int STROBE_ACCESS_NS = 20;
    localparam int EDO_LIMIT_NS = 30;
    localparam int READ_CYCLE_NS = LINK_PERIOD_NS;
    localparam int PAUSE_RESTART_X10 = 15;
    localparam logic [7:0] OP_SET_FEAT = 8'hef;
    localparam logic [7:0] OP_GET_FEAT = 8'hee;
    localparam logic [7:0] OP_READ_ID = 8'h90;
    localparam logic [7:0] OP_STATUS = 8'h70;
    localparam logic [7:0] OP_STATUS_ENH = 8'h78;
    localparam logic [7:0] OP_COL_CHANGE = 8'he0;
    localparam logic [1:0] K_CMD = 2'h0;
    localparam logic [1:0] K_ADDR = 2'h1;
    localparam logic [1:0] K_WRITE = 2'h2;
    localparam logic [1:0] K_READ = 2'h3;

    function automatic int min_cycles(int ns, int per);
        int c;
        c = (ns + per - 1) / per;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [7:0] CS_SETUP_CYC = 8'(min_cycles(CS_SETUP_NS, CLK_PERIOD_NS));
    localparam logic [7:0] CS_HOLD_CYC = 8'(min_cycles(CS_HOLD_NS, CLK_PERIOD_NS));
    localparam logic [7:0] CS_ACCESS_CYC = 8'(min_cycles(CS_ACCESS_NS, CLK_PERIOD_NS));
    localparam logic [7:0] ADL_CYC = 8'(min_cycles(ADDR_TO_DATA_NS, CLK_PERIOD_NS));
    localparam logic [7:0] CCS_CYC = 8'(min_cycles(COL_CHANGE_NS, CLK_PERIOD_NS));
    localparam logic [7:0] RHW_CYC = 8'(min_cycles(READ_HIGH_TO_WRITE_NS, CLK_PERIOD_NS));
    localparam logic [7:0] WHR_CYC = 8'(min_cycles(WRITE_HIGH_TO_READ_NS, CLK_PERIOD_NS));
    localparam logic [7:0] DQSD_CYC = 8'(min_cycles(STROBE_DRIVE_NS, CLK_PERIOD_NS));
    localparam logic [7:0] TURN_CYC = 8'(LINK_DIV * min_cycles(
        STROBE_ACCESS_NS + LINK_PERIOD_NS, LINK_PERIOD_NS));
    localparam logic [7:0] RESTART_CYC = 8'(LINK_DIV * min_cycles(PAUSE_RESTART_X10, 10));
    localparam logic EDO_MODE = (READ_CYCLE_NS < EDO_LIMIT_NS);

    typedef enum logic [3:0] {
        H_IDLE = 4'h0,
        H_SETUP = 4'h1,
        H_RUN = 4'h2,
        H_PAUSE = 4'h3,
        H_RESTART = 4'h4,
        H_RDSTART = 4'h5,
        H_RD = 4'h6,
        H_TURN = 4'h7,
        H_HOLD = 4'h8
    } nbcp_hstate_t;

    function automatic logic [7:0] max8(logic [7:0] a, logic [7:0] b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic dbl_out_cmd(logic [7:0] op);
        return op == OP_READ_ID || op == OP_GET_FEAT || op == OP_STATUS || op == OP_STATUS_ENH;
    endfunction

    function automatic logic busy_cmd(logic [7:0] op);
        return op == 8'h30 || op == 8'h31 || op == 8'h32 || op == 8'h35 || op == 8'h3f ||
            op == 8'hd0 || op == 8'h10 || op == 8'h11 || op == 8'h15 || op == 8'hfc ||
            op == 8'hff || op == OP_SET_FEAT;
    endfunction
endpackage

// file: design/nbcp_sync.sv
`timescale 1ns/100ps
module nbcp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // nbcp_sync

// file: tb/nbcp_sva.sv
`timescale 1ns/100ps
module nbcp_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic wr_n,
    input wire logic dq_h_oe,
    input wire logic dqs_h_oe,
    input wire logic dq_d_oe,
    input wire logic dqs_d_oe,
    input wire logic dqs_d
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_host_off; !wr_n |-> !dq_h_oe && !dqs_h_oe; endproperty
    a_host_off: assert property (p_host_off)
        else $error("host drives the bus while reading");
    property p_dev_off; !wr_n [*8] |-> dq_d_oe && dqs_d_oe; endproperty
    a_dev_off: assert property (p_dev_off)
        else $error("device does not take the bus while it owns it");
    property p_dev_release; $rose(wr_n) |-> (!dq_d_oe && !dqs_d_oe) [*5]; endproperty
    a_dev_release: assert property (p_dev_release)
        else $error("device still drives after turnaround");
    property p_strobe_drive; $fell(wr_n) |-> ##[0:5] (dqs_d_oe && !dqs_d); endproperty
    a_strobe_drive: assert property (p_strobe_drive)
        else $error("device strobe not driven low in time");
    property p_no_early_read; $fell(wr_n) |-> !(cle && ale) [*5]; endproperty
    a_no_early_read: assert property (p_no_early_read)
        else $error("read phase began before the strobe drive delay");
    property p_turn; (!wr_n && $fell(cle && ale)) |-> !wr_n [*8]; endproperty
    a_turn: assert property (p_turn)
        else $error("direction raised too soon after read");
    property p_cs_setup; $fell(ce_n) |-> (!cle && !ale) [*4]; endproperty
    a_cs_setup: assert property (p_cs_setup)
        else $error("latch enable raised before chip select setup");
    property p_cs_hold; $rose(ce_n) |-> $past(link_clk) && $past(link_clk, 2); endproperty
    a_cs_hold: assert property (p_cs_hold)
        else $error("chip select released without hold");
    c_read: cover property ($fell(wr_n));
    c_write: cover property (cle && ale && wr_n);
    c_pause: cover property (link_clk [*8]);
endmodule // nbcp_sva

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
    import nbcp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dev_rst = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] req_kind = K_CMD;
    logic req_last = 1'b0;
    logic [7:0] req_byte = 8'h00;
    logic clk_stop_en = 1'b1;
    logic dev_stop_ok = 1'b1;
    logic busy = 1'b0;
    logic [7:0] rd_val = 8'ha0;
    logic req_ready, rsp_valid, ready, rdata_take, cmd_valid, addr_valid, wdata_valid;
    logic [7:0] rsp_byte, cmd_byte, addr_byte, wdata;
    logic [7:0] cq[$], aq[$], wq[$], rq[$];
    logic [7:0] exp_c[$] = '{8'h80, 8'hef, 8'h70, 8'h00, 8'h70, 8'hff};
    logic [7:0] exp_a[$] = '{8'h01, 8'h02, 8'h10};
    logic [7:0] exp_w[$] = '{8'h11, 8'h22, 8'h33, 8'h04, 8'h05};
    logic [7:0] exp_r[$] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4};
    int err_count = 0;
    int compares = 0;
    int edges = 0;
    always #2 clk = ~clk;
    nbcp_if u_nbcp_if ();
    nbcp_host u_nbcp_host (.clk(clk), .rst(rst), .hif(u_nbcp_if), .req_valid(req_valid),
        .req_kind(req_kind), .req_last(req_last), .req_byte(req_byte), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .clk_stop_en(clk_stop_en),
        .dev_stop_ok(dev_stop_ok), .ready(ready));
    nbcp_device u_nbcp_device (.rst(dev_rst), .dif(u_nbcp_if), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .addr_valid(addr_valid), .addr_byte(addr_byte),
        .wdata_valid(wdata_valid), .wdata(wdata), .rdata(rd_val), .rdata_take(rdata_take),
        .busy(busy));
    nbcp_sva u_nbcp_sva (.clk(clk), .rst(rst), .link_clk(u_nbcp_if.link_clk),
        .ce_n(u_nbcp_if.ce_n), .cle(u_nbcp_if.cle), .ale(u_nbcp_if.ale), .wr_n(u_nbcp_if.wr_n),
        .dq_h_oe(u_nbcp_if.dq_h_oe), .dqs_h_oe(u_nbcp_if.dqs_h_oe),
        .dq_d_oe(u_nbcp_if.dq_d_oe), .dqs_d_oe(u_nbcp_if.dqs_d_oe), .dqs_d(u_nbcp_if.dqs_d));
    // Device pulses last a link period, so they are collected on the falling link edge.
    always @(negedge u_nbcp_if.link_clk) begin
        if (cmd_valid === 1'b1) cq.push_back(cmd_byte);
        if (addr_valid === 1'b1) aq.push_back(addr_byte);
        if (wdata_valid === 1'b1) wq.push_back(wdata);
    end
    always @(posedge u_nbcp_if.link_clk) begin
        edges <= edges + 1;
        if (rdata_take === 1'b1) rd_val <= rd_val + 8'h01;
    end
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) rq.push_back(rsp_byte);
    end
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic req(input logic [1:0] k, input logic [7:0] b, input logic l);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_kind = k;
        req_byte = b;
        req_last = l;
        #1;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(negedge clk);
            #1;
            n++;
        end
        if (n >= 3000) cmp("request taken", 8'h01, 8'h00);
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic idle_edges(output int cnt);
        int e0;
        repeat (20) @(negedge clk);
        e0 = edges;
        repeat (20) @(negedge clk);
        cnt = edges - e0;
    endtask
    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        int cnt;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        dev_rst = 1'b0;
        repeat (8) @(negedge clk);
        // Program with a pause in the write stream.
        req(K_CMD, 8'h80, 1'b0);
        req(K_ADDR, 8'h01, 1'b0);
        req(K_ADDR, 8'h02, 1'b0);
        req(K_WRITE, 8'h11, 1'b0);
        req(K_WRITE, 8'h22, 1'b0);
        idle_edges(cnt);
        cmp("paused link edges", 8'h00, 8'(cnt));
        req(K_WRITE, 8'h33, 1'b1);
        // Doubled write bytes with the clock kept running.
        dev_stop_ok = 1'b0;
        req(K_CMD, OP_SET_FEAT, 1'b0);
        req(K_ADDR, 8'h10, 1'b0);
        req(K_WRITE, 8'h04, 1'b0);
        idle_edges(cnt);
        cmp("running link edges", 8'h01, 8'(cnt > 0));
        req(K_WRITE, 8'h05, 1'b1);
        // Doubled status bytes, then plain reads.
        req(K_CMD, OP_STATUS, 1'b0);
        repeat (2) req(K_READ, 8'h00, 1'b0);
        req(K_READ, 8'h00, 1'b1);
        req(K_CMD, 8'h00, 1'b0);
        req(K_READ, 8'h00, 1'b0);
        req(K_READ, 8'h00, 1'b1);
        // Busy shows only after a command that may go busy.
        busy = 1'b1;
        req(K_CMD, OP_STATUS, 1'b1);
        repeat (40) @(negedge clk);
        cmp("ready after status", 8'h01, {7'h00, ready});
        req(K_CMD, 8'hff, 1'b1);
        repeat (40) @(negedge clk);
        cmp("ready after reset cmd", 8'h00, {7'h00, ready});
        busy = 1'b0;
        repeat (40) @(negedge clk);
        cmp("ready after busy ends", 8'h01, {7'h00, ready});
        foreach (exp_c[i]) cmp("cmd byte", exp_c[i], cq[i]);
        foreach (exp_a[i]) cmp("addr byte", exp_a[i], aq[i]);
        foreach (exp_w[i]) cmp("write byte", exp_w[i], wq[i]);
        cmp("write count", 8'h05, 8'(wq.size()));
        foreach (exp_r[i]) cmp("read byte", exp_r[i], rq[i]);
        cmp("read count", 8'h05, 8'(rq.size()));
        results();
    end
endmodule // tb
